// ---- lnt_pkg.sv ----
package lnt_pkg;
  localparam int CLK_PERIOD_NS = 8;
  localparam int DOM_TIMEOUT_NS = 6000000;
  localparam int DOM_REARM_NS = 10000;
  localparam int BUS_WAKE_NS = 90000;
  localparam int LOCAL_WAKE_NS = 35000;
  localparam int LOCAL_REARM_NS = 6000;
  localparam int EN_SLEEP_NS = 5000;
  localparam int EN_NORMAL_NS = 5000;
  // least times, rounded up to whole cycles
  localparam int DOM_TIMEOUT_CYC = (DOM_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DOM_REARM_CYC = (DOM_REARM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUS_WAKE_CYC = (BUS_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOCAL_WAKE_CYC = (LOCAL_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOCAL_REARM_CYC = (LOCAL_REARM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EN_SLEEP_CYC = (EN_SLEEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EN_NORMAL_CYC = (EN_NORMAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  localparam logic [3:0] WAKECNT_OFS = 4'h8;
  localparam int CTRL_TXBLOCK_BIT = 0;
  localparam int CTRL_LWAKE_EN_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h2;
  localparam int WAKECNT_W = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    LNT_FAILSAFE = 2'b00,
    LNT_NORMAL = 2'b01,
    LNT_SLEEP = 2'b10
  } lnt_mode_t;

  typedef struct packed {
    logic local_armed;
    logic undervolt;
    logic dom_timeout;
    logic wake_local;
    logic wake_flag;
    lnt_mode_t mode;
  } lnt_status_t;

  typedef struct packed {
    logic en;
    logic txd;
    logic wake;
    logic lin;
    logic uv;
  } lnt_pins_t;
endpackage : lnt_pkg

// ---- lnt_core.sv ----
`timescale 1ns/1ps
// true once lvl has stayed high for at least N cycles; any change restarts the count
module lnt_hold #(
  parameter int N = 4
) (
  input wire logic clock, // system clock
  input wire logic rst, // async reset
  input wire logic ce, // clock enable
  input wire logic lvl, // monitored level
  output logic held // lvl high and stable N cycles
);
  localparam int W = $clog2(N + 1);
  localparam logic [W-1:0] LIM = W'(N);
  logic lvl_q_r;
  logic [W-1:0] cnt_r;

  initial begin
    if (N < 1) $error("lnt_hold: N must be at least 1");
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lvl_q_r <= 1'b0;
      cnt_r <= '0;
    end else if (ce) begin
      lvl_q_r <= lvl;
      if (lvl != lvl_q_r) begin
        cnt_r <= '0;
      end else if (cnt_r != LIM) begin
        cnt_r <= cnt_r + W'(1);
      end
    end
  end

  assign held = lvl_q_r && (cnt_r == LIM);
endmodule : lnt_hold

module lnt_core
  import lnt_pkg::*;
#(
  parameter int DOM_CYC = DOM_TIMEOUT_CYC,
  parameter int BUS_CYC = BUS_WAKE_CYC,
  parameter int LWAKE_CYC = LOCAL_WAKE_CYC,
  parameter int ADDR_W = 4
) (
  input wire logic clock, // 125 MHz clock
  input wire logic rst, // async reset, active high
  input wire logic ce, // clock enable, freezes all state
  input wire logic en_in, // enable pin
  input wire logic wake_in, // local wake pin, low active
  input wire logic battery_supply_low, // supply undervoltage detect
  input wire logic txd_in, // transmit pin level
  output logic txd_out, // transmit pin drive value
  output logic txd_oe, // transmit pin strong pull-down
  output logic txd_weak_pd, // transmit pin weak pull-down only
  input wire logic lin_in, // bus level
  output logic lin_out, // bus drive value
  output logic lin_oe, // bus driven dominant
  output logic rxd_out, // receive pin drive value
  output logic rxd_oe, // receive pin pulled low
  output logic regulator_inhibit_out, // regulator inhibit
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready // read data ready
);
  initial begin
    if (ADDR_W < 4) $error("lnt_core: ADDR_W must be at least 4");
    if (DOM_CYC < 1 || BUS_CYC < 1 || LWAKE_CYC < 1) $error("lnt_core: counts must be >= 1");
  end
  lnt_pins_t pins, meta_r, sync_r;
  lnt_mode_t mode_r, mode_nxt;
  lnt_status_t status;
  logic en_d_r, sleep_pend_r, dom_to_r, bus_rec_seen_r;
  logic local_armed_r, wake_flag_r, wake_local_r;
  logic [WAKECNT_W-1:0] wake_cnt_r;
  logic [1:0] ctrl_r;
  logic dom_held, rearm_held, bus_held, lwake_held, lrearm_held, sleep_held, normal_held;
  logic bus_wake, local_wake, tx_ok, do_write;
  logic aw_got_r, w_got_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  assign pins = '{en: en_in, txd: txd_in, wake: wake_in, lin: lin_in, uv: battery_supply_low};

  // every pin crosses two flops before use
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_r <= '0;
      sync_r <= '0;
    end else if (ce) begin
      meta_r <= pins;
      sync_r <= meta_r;
    end
  end

  lnt_hold #(.N(DOM_CYC)) u_dom (.clock(clock), .rst(rst), .ce(ce),
    .lvl(!sync_r.txd), .held(dom_held));
  lnt_hold #(.N(DOM_REARM_CYC)) u_rearm (.clock(clock), .rst(rst), .ce(ce),
    .lvl(sync_r.txd), .held(rearm_held));
  lnt_hold #(.N(BUS_CYC)) u_bus (.clock(clock), .rst(rst), .ce(ce),
    .lvl(!sync_r.lin), .held(bus_held));
  lnt_hold #(.N(LWAKE_CYC)) u_lwake (.clock(clock), .rst(rst), .ce(ce),
    .lvl(!sync_r.wake), .held(lwake_held));
  lnt_hold #(.N(LOCAL_REARM_CYC)) u_lrearm (.clock(clock), .rst(rst), .ce(ce),
    .lvl(sync_r.wake), .held(lrearm_held));
  // low or open enable asks for sleep; sleep entry debounce
  lnt_hold #(.N(EN_SLEEP_CYC)) u_ensleep (.clock(clock), .rst(rst), .ce(ce),
    .lvl(!sync_r.en), .held(sleep_held));
  lnt_hold #(.N(EN_NORMAL_CYC)) u_ennorm (.clock(clock), .rst(rst), .ce(ce),
    .lvl(sync_r.en), .held(normal_held));
  // bus wake needs a fresh dominant phase inside sleep
  assign bus_wake = (mode_r == LNT_SLEEP) && bus_rec_seen_r && bus_held;
  assign local_wake = (mode_r == LNT_SLEEP) && local_armed_r && lwake_held
                      && ctrl_r[CTRL_LWAKE_EN_BIT];

  always_comb begin
    mode_nxt = mode_r;
    unique case (mode_r)
      LNT_FAILSAFE: begin
        if (normal_held) mode_nxt = LNT_NORMAL;
      end
      LNT_NORMAL: begin
        if (sleep_pend_r && sleep_held) mode_nxt = LNT_SLEEP;
      end
      LNT_SLEEP: begin
        if (bus_wake || local_wake) begin
          mode_nxt = LNT_FAILSAFE;
        end else if (normal_held) begin
          mode_nxt = LNT_NORMAL;
        end
      end
      default: mode_nxt = LNT_FAILSAFE;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mode_r <= LNT_FAILSAFE;
    end else if (ce) begin
      mode_r <= mode_nxt;
    end
  end

  // falling edge taken only with transmit high; bus and wake pins ignored
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      en_d_r <= 1'b0;
      sleep_pend_r <= 1'b0;
    end else if (ce) begin
      en_d_r <= sync_r.en;
      if (en_d_r && !sync_r.en && sync_r.txd && mode_r == LNT_NORMAL) begin
        sleep_pend_r <= 1'b1;
      end else if (sync_r.en || mode_r != LNT_NORMAL) begin
        sleep_pend_r <= 1'b0;
      end
    end
  end

  // cleared only after a long enough high
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dom_to_r <= 1'b0;
    end else if (ce) begin
      if (mode_r == LNT_NORMAL && dom_held) begin
        dom_to_r <= 1'b1;
      end else if (rearm_held) begin
        dom_to_r <= 1'b0;
      end
    end
  end

  // a bus stuck dominant on entry must not wake us at once
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bus_rec_seen_r <= 1'b0;
    end else if (ce) begin
      if (mode_r != LNT_SLEEP) begin
        bus_rec_seen_r <= 1'b0;
      end else if (sync_r.lin) begin
        bus_rec_seen_r <= 1'b1;
      end
    end
  end

  // arm on a long high; disarm on a local wake or on a low pin outside sleep
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      local_armed_r <= 1'b0;
    end else if (ce) begin
      if (local_wake || (mode_r != LNT_SLEEP && !sync_r.wake)) begin
        local_armed_r <= 1'b0;
      end else if (lrearm_held) begin
        local_armed_r <= 1'b1;
      end
    end
  end

  // enable high clears both flags; a wake in the same cycle wins
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wake_flag_r <= 1'b0;
      wake_local_r <= 1'b0;
      wake_cnt_r <= '0;
    end else if (ce) begin
      if (bus_wake || local_wake) begin
        wake_flag_r <= 1'b1;
        wake_local_r <= local_wake;
        wake_cnt_r <= wake_cnt_r + WAKECNT_W'(1);
      end else if (sync_r.en) begin
        wake_flag_r <= 1'b0;
        wake_local_r <= 1'b0;
      end
    end
  end

  assign tx_ok = (mode_r == LNT_NORMAL) && !sync_r.uv && !dom_to_r
                 && !ctrl_r[CTRL_TXBLOCK_BIT];

  // pin drivers, all registered
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lin_out <= 1'b0;
      lin_oe <= 1'b0;
      rxd_out <= 1'b0;
      rxd_oe <= 1'b0;
      txd_out <= 1'b0;
      txd_oe <= 1'b0;
      txd_weak_pd <= 1'b0;
      regulator_inhibit_out <= 1'b1;
    end else if (ce) begin
      lin_out <= 1'b0;
      rxd_out <= 1'b0;
      txd_out <= 1'b0;
      lin_oe <= tx_ok && !sync_r.txd;
      // follow bus; low as wake request
      rxd_oe <= (mode_r == LNT_NORMAL) ? !sync_r.lin
                : ((mode_r == LNT_FAILSAFE) && wake_flag_r);
      txd_oe <= (mode_r == LNT_FAILSAFE) && wake_flag_r && wake_local_r;
      txd_weak_pd <= (mode_r == LNT_FAILSAFE) && wake_flag_r && !wake_local_r;
      regulator_inhibit_out <= (mode_nxt != LNT_SLEEP);
    end
  end

  assign status = '{local_armed: local_armed_r, undervolt: sync_r.uv, dom_timeout: dom_to_r,
                    wake_local: wake_local_r, wake_flag: wake_flag_r, mode: mode_r};

  // register bus: address and data are taken in either order
  assign do_write = aw_got_r && w_got_r && !s_axi_bvalid;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      aw_got_r <= 1'b0;
      awaddr_r <= '0;
      s_axi_awready <= 1'b0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (do_write) begin
        aw_got_r <= 1'b0;
      end else if (!aw_got_r && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      w_got_r <= 1'b0;
      wdata_r <= '0;
      wstrb_r <= '0;
      s_axi_wready <= 1'b0;
    end else if (ce) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (do_write) begin
        w_got_r <= 1'b0;
      end else if (!w_got_r && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  // only the low byte of the control word holds bits
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_r <= CTRL_RST;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (ce) begin
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        if (awaddr_r[3:0] == CTRL_OFS) begin
          s_axi_bresp <= RESP_OKAY;
          if (wstrb_r[0]) ctrl_r <= wdata_r[1:0];
        end else if (awaddr_r[3:0] == STATUS_OFS || awaddr_r[3:0] == WAKECNT_OFS) begin
          s_axi_bresp <= RESP_OKAY;
        end else begin
          s_axi_bresp <= RESP_SLVERR;
        end
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        if (s_axi_araddr[3:0] == CTRL_OFS) begin
          s_axi_rdata <= {30'h0, ctrl_r};
        end else if (s_axi_araddr[3:0] == STATUS_OFS) begin
          s_axi_rdata <= {25'h0, status};
        end else if (s_axi_araddr[3:0] == WAKECNT_OFS) begin
          s_axi_rdata <= {16'h0, wake_cnt_r};
        end else begin
          s_axi_rdata <= '0;
          s_axi_rresp <= RESP_SLVERR;
        end
      end else if (s_axi_rvalid) begin
        if (s_axi_rready) s_axi_rvalid <= 1'b0;
      end else begin
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule : lnt_core

// ---- lnt_core_chk.sv ----
`timescale 1ns/1ps
module lnt_core_chk (
  input wire logic clock, // clock
  input wire logic rst, // reset
  input wire logic en_in, // enable
  input wire logic wake_in, // wake pin
  input wire logic battery_supply_low, // low supply
  input wire logic txd_in, // tx pin
  input wire logic txd_oe, // tx strong
  input wire logic txd_weak_pd, // tx weak
  input wire logic lin_in, // bus
  input wire logic lin_oe, // bus drive
  input wire logic rxd_oe, // rx low
  input wire logic regulator_inhibit_out // inhibit
);
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (rst);
  // pin paths are 2 sync flops plus an output flop, so 3 samples of lag
  property p_uv_block;
    battery_supply_low [*5] |-> !lin_oe;
  endproperty
  a_uv_block: assert property (p_uv_block) else $error("bus driven at low supply");
  property p_reset_inh;
    $fell(rst) |-> regulator_inhibit_out && !lin_oe;
  endproperty
  a_reset_inh: assert property (p_reset_inh) else $error("inhibit off after reset");
  property p_tx_follow;
    lin_oe |-> !$past(txd_in, 3);
  endproperty
  a_tx_follow: assert property (p_tx_follow) else $error("bus driven with tx high");
  property p_rx_follow;
    rxd_oe && !txd_oe && !txd_weak_pd |-> !$past(lin_in, 3);
  endproperty
  a_rx_follow: assert property (p_rx_follow) else $error("rx low on recessive bus");
  // one cycle allowed for the outputs to settle after the mode flips
  property p_sleep_quiet;
    !regulator_inhibit_out [*2] |-> !lin_oe && !rxd_oe && !txd_oe;
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet) else $error("activity in sleep");
  property p_sleep_entry;
    $fell(regulator_inhibit_out) |-> !$past(en_in, 5) && !$past(en_in, 300);
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep without enable low");
  property p_bus_wake;
    $rose(txd_weak_pd) |-> !$past(lin_in, 6) && !$past(lin_in, 40) && !txd_oe;
  endproperty
  a_bus_wake: assert property (p_bus_wake) else $error("bus wake without dominant");
  property p_loc_wake;
    $rose(txd_oe) |-> !$past(wake_in, 6) && !$past(wake_in, 30);
  endproperty
  a_loc_wake: assert property (p_loc_wake) else $error("local wake without low pin");
  property p_wake_rxd;
    $rose(txd_oe) || $rose(txd_weak_pd) |-> rxd_oe && regulator_inhibit_out;
  endproperty
  a_wake_rxd: assert property (p_wake_rxd) else $error("wake not flagged");
  property p_en_clear;
    en_in [*6] |-> !txd_oe && !txd_weak_pd;
  endproperty
  a_en_clear: assert property (p_en_clear) else $error("wake source not cleared");
  c_local: cover property ($rose(txd_oe));
  c_remote: cover property ($rose(txd_weak_pd));
  c_sleep: cover property ($fell(regulator_inhibit_out));
endmodule : lnt_core_chk
bind lnt_core lnt_core_chk u_chk (.clock(clock), .rst(rst), .en_in(en_in), .wake_in(wake_in),
  .battery_supply_low(battery_supply_low), .txd_in(txd_in), .txd_oe(txd_oe),
  .txd_weak_pd(txd_weak_pd), .lin_in(lin_in), .lin_oe(lin_oe), .rxd_oe(rxd_oe),
  .regulator_inhibit_out(regulator_inhibit_out));

// ---- lnt_node.sv ----
`timescale 1ns/1ps
// controller and remote node at the pins, board pull-ups on every line
module lnt_node (
  input wire logic mcu_txd, // controller tx, 1 when released
  input wire logic node_dom, // remote node pulls bus dominant
  input wire logic txd_out, // device tx drive
  input wire logic txd_oe, // device tx strong drive
  input wire logic lin_out, // device bus drive
  input wire logic lin_oe, // device bus enable
  input wire logic rxd_out, // device rx drive
  input wire logic rxd_oe, // device rx enable
  output logic txd_pin, // resolved tx line
  output logic lin_pin, // resolved bus
  output logic rxd_pin // resolved rx line
);
  // strong drive wins, a weak pull-down loses to the pull-up
  assign txd_pin = txd_oe ? txd_out : mcu_txd;
  assign lin_pin = (lin_oe ? lin_out : 1'h1) & ~node_dom;
  assign rxd_pin = rxd_oe ? rxd_out : 1'h1;
endmodule : lnt_node

// ---- tb.sv ----
`timescale 1ns/1ps
module tb;
  import lnt_pkg::*;
  logic clock = 1'h0;
  logic rst = 1'h1;
  logic en = 1'h0;
  logic wk = 1'h1;
  logic uv = 1'h0;
  logic tx = 1'h1;
  logic nd = 1'h0;
  logic ce = 1'h1;
  logic txd_out, txd_oe, txd_weak_pd, lin_out, lin_oe, rxd_out, rxd_oe, reg_on;
  logic txd_pin, lin_pin, rxd_pin, awready, wready, bvalid, arready, rvalid;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [1:0] bresp, rresp;
  // tx, remote node, expected bus, expected rx
  logic [3:0] rows [4] = '{4'h0, 4'hb, 4'hc, 4'h4};
  int n_errors = 0;
  int total_checks = 0;
  always #4 clock = ~clock;
  lnt_core #(.DOM_CYC(200), .BUS_CYC(60), .LWAKE_CYC(40)) uut (.clock(clock), .rst(rst),
    .ce(ce), .en_in(en), .wake_in(wk), .battery_supply_low(uv), .txd_in(txd_pin),
    .txd_out(txd_out), .txd_oe(txd_oe), .txd_weak_pd(txd_weak_pd), .lin_in(lin_pin),
    .lin_out(lin_out), .lin_oe(lin_oe), .rxd_out(rxd_out), .rxd_oe(rxd_oe),
    .regulator_inhibit_out(reg_on), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  lnt_node u_node (.mcu_txd(tx), .node_dom(nd), .txd_out(txd_out), .txd_oe(txd_oe),
    .lin_out(lin_out), .lin_oe(lin_oe), .rxd_out(rxd_out), .rxd_oe(rxd_oe),
    .txd_pin(txd_pin), .lin_pin(lin_pin), .rxd_pin(rxd_pin));
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : cyc
  task automatic bound(input int n);
    if (n < 64) return;
    chk(34'h0, 34'h1);
    final_report();
  endtask : bound
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (n = 0; n < 64; n++) begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid) break;
    end
    bready <= 1'h0;
    bound(n);
    chk(bresp, RESP_OKAY);
  endtask : wr
  // compares response and masked data in one go
  task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [33:0] exp);
    int n;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (n = 0; n < 64; n++) begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid) break;
    end
    rready <= 1'h0;
    bound(n);
    chk({rresp, rdata & m}, exp);
  endtask : rd
  initial begin
    cyc(3);
    chk(reg_on, 1'h1);
    cyc(1);
    rst <= 1'h0;
    cyc(4);
    rd(STATUS_OFS, 32'h3, {RESP_OKAY, 32'h0});
    rd(CTRL_OFS, 32'h3, {RESP_OKAY, 32'h2});
    rd(4'hc, 32'hffffffff, {RESP_SLVERR, 32'h0});
    en <= 1'h1;
    tx <= 1'h0;
    cyc(300);
    chk(lin_pin, 1'h1);
    tx <= 1'h1;
    cyc(400);
    rd(STATUS_OFS, 32'h3, {RESP_OKAY, 32'h1});
    for (int i = 0; i < 4; i++) begin
      tx <= rows[i][3];
      nd <= rows[i][2];
      cyc(8);
      chk(lin_pin, rows[i][1]);
      chk(rxd_pin, rows[i][0]);
    end
    tx <= 1'h1;
    nd <= 1'h0;
    en <= 1'h0;
    cyc(50);
    en <= 1'h1;
    cyc(10);
    rd(STATUS_OFS, 32'h3, {RESP_OKAY, 32'h1});
    // a frozen clock enable keeps the bus released
    ce <= 1'h0;
    tx <= 1'h0;
    cyc(8);
    chk(lin_pin, 1'h1);
    ce <= 1'h1;
    uv <= 1'h1;
    tx <= 1'h0;
    cyc(8);
    chk(lin_pin, 1'h1);
    uv <= 1'h0;
    cyc(8);
    chk(lin_pin, 1'h0);
    wr(CTRL_OFS, 32'h3);
    cyc(6);
    chk(lin_pin, 1'h1);
    chk({txd_out, lin_out, rxd_out}, 3'h0);
    wr(CTRL_OFS, 32'h2);
    cyc(6);
    chk(lin_pin, 1'h0);
    cyc(200);
    chk(lin_pin, 1'h1);
    rd(STATUS_OFS, 32'h10, {RESP_OKAY, 32'h10});
    // too short a recessive spell must keep the driver off
    tx <= 1'h1;
    cyc(DOM_REARM_CYC / 2);
    tx <= 1'h0;
    cyc(8);
    chk(lin_pin, 1'h1);
    tx <= 1'h1;
    cyc(DOM_REARM_CYC + 20);
    tx <= 1'h0;
    cyc(8);
    chk(lin_pin, 1'h0);
    tx <= 1'h1;
    nd <= 1'h1;
    wk <= 1'h0;
    cyc(4);
    en <= 1'h0;
    cyc(EN_SLEEP_CYC + 60);
    chk(reg_on, 1'h0);
    rd(STATUS_OFS, 32'h3, {RESP_OKAY, 32'h2});
    tx <= 1'h0;
    nd <= 1'h0;
    cyc(10);
    chk(lin_oe, 1'h0);
    tx <= 1'h1;
    wk <= 1'h1;
    cyc(LOCAL_REARM_CYC + 20);
    wk <= 1'h0;
    cyc(20);
    wk <= 1'h1;
    cyc(10);
    chk(reg_on, 1'h0);
    cyc(LOCAL_REARM_CYC + 20);
    wk <= 1'h0;
    cyc(60);
    chk(reg_on, 1'h1);
    chk(txd_pin, 1'h0);
    chk(rxd_pin, 1'h0);
    rd(STATUS_OFS, 32'hf, {RESP_OKAY, 32'hc});
    wk <= 1'h1;
    en <= 1'h1;
    cyc(6);
    chk({txd_pin, rxd_pin}, 2'h3);
    cyc(EN_NORMAL_CYC + 20);
    rd(STATUS_OFS, 32'hf, {RESP_OKAY, 32'h1});
    en <= 1'h0;
    cyc(EN_SLEEP_CYC + 60);
    chk(reg_on, 1'h0);
    nd <= 1'h1;
    cyc(30);
    nd <= 1'h0;
    cyc(10);
    chk(reg_on, 1'h0);
    nd <= 1'h1;
    cyc(80);
    chk(reg_on, 1'h1);
    chk({txd_weak_pd, txd_pin}, 2'h3);
    chk(rxd_pin, 1'h0);
    nd <= 1'h0;
    rd(STATUS_OFS, 32'hf, {RESP_OKAY, 32'h4});
    rd(WAKECNT_OFS, 32'hffff, {RESP_OKAY, 32'h2});
    // a second reset in mid-run clears the wake state
    rst <= 1'h1;
    cyc(2);
    chk(reg_on, 1'h1);
    rst <= 1'h0;
    cyc(4);
    rd(STATUS_OFS, 32'hf, {RESP_OKAY, 32'h0});
    rd(WAKECNT_OFS, 32'hffff, {RESP_OKAY, 32'h0});
    final_report();
  end
endmodule : tb
